// *** pkg/flash_prot_map.svh ***
`ifndef FLASH_PROT_MAP_SVH
`define FLASH_PROT_MAP_SVH

// ========================================================================
// Software register byte offsets.
`define REG_CTRL        8'h00
`define REG_ADDR        8'h04
`define REG_WDATA       8'h08
`define REG_RDATA       8'h0c
`define REG_STAT        8'h10
`define REG_INT_STATUS  8'h14
`define REG_INT_ENABLE  8'h18
`define REG_INT_CLEAR   8'h1c

// ========================================================================
// Operation codes written to the control register.
`define OP_ARRAY        3'h1
`define OP_CONFIG       3'h2
`define OP_READ         3'h3
`define OP_PROG         3'h4
`define OP_LOCK         3'h5

// ========================================================================
// Flash command codes and the lock word.
`define CMD_READ_ARRAY  16'h00ff
`define CMD_READ_CONFIG 16'h0090
`define CMD_PROT_SETUP  16'h00c0
`define LOCK_WORD_DATA  16'hfffd
`define LOCK_WORD_ADDR  20'h00080

// ========================================================================
// Flash status byte bit positions.
`define SR_READY        7
`define SR_PROG_ERR     4
`define SR_SUPPLY_ERR   3
`define SR_LOCK_ERR     1

// ========================================================================
// Interrupt bit positions.
`define INT_DONE        0
`define INT_PROG_ERR    1
`define INT_LOCK_ERR    2
`define INT_SUPPLY_ERR  3

// ========================================================================
// Timing: clock period, access time and write pulse width in ns.
`define CLK_NS          50
`define T_ACC_NS        70
`define T_WP_NS         70
`define ACC_CYC         ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define WP_CYC          ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)
`define RD_CYC          (`ACC_CYC + 2)

`endif

// *** pkg/flash_prot_pkg.sv ***
`default_nettype none

package flash_prot_pkg;

   // One flash bus cycle request.
   typedef struct packed {
      logic        wr;
      logic [19:0] addr;
      logic [15:0] data;
   } flash_req_t;

   // Flash bus pins driven by the host.
   typedef struct packed {
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        dq_oe;
      logic [19:0] addr;
      logic [15:0] dq;
   } flash_pins_t;

endpackage

`default_nettype wire

// *** src/flash_cycle_engine.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "flash_prot_map.svh"

module flash_cycle_engine
   import flash_prot_pkg::*;
(
   input  wire logic        mclk_in,    // System clock.
   input  wire logic        sys_rst_in, // Asynchronous reset.
   input  wire logic        start_in,   // Start one bus cycle.
   input  wire flash_req_t  req_in,     // Cycle kind, address, data.
   input  wire logic [15:0] dq_in,      // Flash data pins in.
   output flash_pins_t      pins_out,   // Flash pin drive.
   output logic             done_out,   // Cycle finished pulse.
   output logic [15:0]      rdata_out   // Data captured by a read.
);

   typedef enum logic [1:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD} eng_st_t;

   eng_st_t     st_ff;
   logic [2:0]  cnt_ff;
   logic        wr_ff;
   logic [15:0] dq_s1_ff;
   logic [15:0] dq_s2_ff;

   // ======================================================================
   // Data pins pass two flip-flops before use.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         dq_s1_ff <= 16'h0000;
         dq_s2_ff <= 16'h0000;
      end else begin
         dq_s1_ff <= dq_in;
         dq_s2_ff <= dq_s1_ff;
      end
   end

   // ======================================================================
   // Sequencer: setup, strobe pulse, hold, release.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_ff     <= E_IDLE;
         cnt_ff    <= 3'h0;
         wr_ff     <= 1'b0;
         done_out  <= 1'b0;
         rdata_out <= 16'h0000;
         pins_out  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0,
                        addr: 20'h00000, dq: 16'h0000};
      end else begin
         done_out <= 1'b0;
         case (st_ff)
            E_IDLE: begin
               if (start_in) begin
                  wr_ff          <= req_in.wr;
                  pins_out.addr  <= req_in.addr;
                  pins_out.dq    <= req_in.data;
                  pins_out.dq_oe <= req_in.wr;
                  pins_out.ce_n  <= 1'b0;
                  st_ff          <= E_SETUP;
               end
            end
            E_SETUP: begin
               // Assert the strobe and load its width.
               if (wr_ff) begin
                  pins_out.we_n <= 1'b0;
                  cnt_ff        <= 3'(`WP_CYC - 1);
               end else begin
                  pins_out.oe_n <= 1'b0;
                  cnt_ff        <= 3'(`RD_CYC - 1);
               end
               st_ff <= E_PULSE;
            end
            E_PULSE: begin
               if (cnt_ff == 3'h0) begin
                  pins_out.we_n <= 1'b1;
                  pins_out.oe_n <= 1'b1;
                  rdata_out     <= wr_ff ? rdata_out : dq_s2_ff;
                  st_ff         <= E_HOLD;
               end else begin
                  cnt_ff <= cnt_ff - 3'h1;
               end
            end
            E_HOLD: begin
               // Data held one cycle past the rising write strobe.
               pins_out.ce_n  <= 1'b1;
               pins_out.dq_oe <= 1'b0;
               done_out       <= 1'b1;
               st_ff          <= E_IDLE;
            end
            default: st_ff <= E_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// *** src/flash_prot_host.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "flash_prot_map.svh"

module flash_prot_host
   import flash_prot_pkg::*;
(
   input  wire logic        mclk_in,       // System clock, 20 MHz.
   input  wire logic        sys_rst_in,    // Asynchronous reset, high.
   input  wire logic [7:0]  reg_addr_in,   // Register byte address.
   input  wire logic [31:0] reg_wdata_in,  // Register write data.
   input  wire logic        reg_wr_in,     // Register write strobe.
   input  wire logic        reg_rd_in,     // Register read strobe.
   output logic [31:0]      reg_rdata_out, // Read data, next cycle.
   output logic             irq_out,       // Level interrupt.
   output logic             fl_rst_n_out,  // Flash reset, low active.
   output logic             fl_ce_n_out,   // Flash chip enable.
   output logic             fl_oe_n_out,   // Flash output enable.
   output logic             fl_we_n_out,   // Flash write enable.
   output logic [19:0]      fl_addr_out,   // Flash address.
   output logic [15:0]      fl_dq_out,     // Flash data out.
   output logic             fl_dq_oe_out,  // High while host drives data.
   input  wire logic [15:0] fl_dq_in       // Flash data in.
);

   typedef enum logic [2:0] {S_IDLE, S_W1, S_W2, S_POLL, S_RD} host_st_t;

   host_st_t    state_ff;
   logic [2:0]  op_ff;
   logic [19:0] addr_ff;
   logic [15:0] wdata_ff;
   logic [15:0] rdata_ff;
   logic [7:0]  sr_ff;
   logic [3:0]  int_stat_ff;
   logic [3:0]  int_en_ff;
   logic        start_ff;
   flash_req_t  req_ff;
   flash_pins_t pins;
   logic        cyc_done;
   logic [15:0] cyc_rdata;
   logic        ctrl_wr;
   logic        prog_op;
   logic [3:0]  evt;
   logic [3:0]  int_clr;

   // ======================================================================
   // Bus cycle engine.
   flash_cycle_engine u_eng (
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .start_in   (start_ff),
      .req_in     (req_ff),
      .dq_in      (fl_dq_in),
      .pins_out   (pins),
      .done_out   (cyc_done),
      .rdata_out  (cyc_rdata)
   );

   // Pin outputs come from engine flip-flops.
   assign fl_ce_n_out  = pins.ce_n;
   assign fl_oe_n_out  = pins.oe_n;
   assign fl_we_n_out  = pins.we_n;
   assign fl_addr_out  = pins.addr;
   assign fl_dq_out    = pins.dq;
   assign fl_dq_oe_out = pins.dq_oe;

   // ======================================================================
   // Control write is taken only when idle.
   assign ctrl_wr = reg_wr_in && (reg_addr_in == `REG_CTRL) &&
                    (state_ff == S_IDLE);
   assign prog_op = (op_ff == `OP_PROG) || (op_ff == `OP_LOCK);
   assign int_clr = (reg_wr_in && (reg_addr_in == `REG_INT_CLEAR)) ?
                    reg_wdata_in[3:0] : 4'h0;

   // Events: completion and flash status error flags.
   always_comb begin
      evt = 4'h0;
      if (cyc_done && ((state_ff == S_RD) ||
                       ((state_ff == S_W1) && !prog_op))) begin
         evt[`INT_DONE] = 1'b1;
      end
      if (cyc_done && (state_ff == S_POLL) && cyc_rdata[`SR_READY]) begin
         evt[`INT_DONE]       = 1'b1;
         evt[`INT_PROG_ERR]   = cyc_rdata[`SR_PROG_ERR];
         evt[`INT_LOCK_ERR]   = cyc_rdata[`SR_LOCK_ERR];
         evt[`INT_SUPPLY_ERR] = cyc_rdata[`SR_SUPPLY_ERR];
      end
   end

   // ======================================================================
   // Software-written registers.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         addr_ff   <= 20'h00000;
         wdata_ff  <= 16'h0000;
         int_en_ff <= 4'h0;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `REG_ADDR:       addr_ff   <= reg_wdata_in[19:0];
            `REG_WDATA:      wdata_ff  <= reg_wdata_in[15:0];
            `REG_INT_ENABLE: int_en_ff <= reg_wdata_in[3:0];
            default:         addr_ff   <= addr_ff;
         endcase
      end
   end

   // ======================================================================
   // Sticky interrupt status; a set wins over a clear.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         int_stat_ff <= 4'h0;
         irq_out     <= 1'b0;
      end else begin
         int_stat_ff <= (int_stat_ff & ~int_clr) | evt;
         irq_out     <= |(((int_stat_ff & ~int_clr) | evt) & int_en_ff);
      end
   end

   // ======================================================================
   // Register read data, one cycle after the read strobe.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= 32'h00000000;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `REG_CTRL:       reg_rdata_out <= {29'h0, op_ff};
            `REG_ADDR:       reg_rdata_out <= {12'h000, addr_ff};
            `REG_WDATA:      reg_rdata_out <= {16'h0000, wdata_ff};
            `REG_RDATA:      reg_rdata_out <= {16'h0000, rdata_ff};
            `REG_STAT:       reg_rdata_out <= {16'h0000, sr_ff, 7'h00,
                                               state_ff != S_IDLE};
            `REG_INT_STATUS: reg_rdata_out <= {28'h0000000, int_stat_ff};
            `REG_INT_ENABLE: reg_rdata_out <= {28'h0000000, int_en_ff};
            default:         reg_rdata_out <= 32'h00000000;
         endcase
      end else begin
         reg_rdata_out <= 32'h00000000;
      end
   end

   // ======================================================================
   // Flash reset released once the host leaves reset.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         fl_rst_n_out <= 1'b0;
      end else begin
         fl_rst_n_out <= 1'b1;
      end
   end

   // ======================================================================
   // Command sequencer.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_ff <= S_IDLE;
         op_ff    <= 3'h0;
         start_ff <= 1'b0;
         req_ff   <= '0;
         rdata_ff <= 16'h0000;
         sr_ff    <= 8'h00;
      end else begin
         start_ff <= 1'b0;
         case (state_ff)
            S_IDLE: begin
               if (ctrl_wr) begin
                  op_ff <= reg_wdata_in[2:0];
                  case (reg_wdata_in[2:0])
                     `OP_ARRAY: begin
                        req_ff   <= '{1'b1, addr_ff,
                                      `CMD_READ_ARRAY};
                        start_ff <= 1'b1;
                        state_ff <= S_W1;
                     end
                     `OP_CONFIG: begin
                        req_ff   <= '{1'b1, addr_ff,
                                      `CMD_READ_CONFIG};
                        start_ff <= 1'b1;
                        state_ff <= S_W1;
                     end
                     `OP_READ: begin
                        req_ff   <= '{1'b0, addr_ff, 16'h0000};
                        start_ff <= 1'b1;
                        state_ff <= S_RD;
                     end
                     `OP_PROG, `OP_LOCK: begin
                        req_ff   <= '{1'b1, addr_ff,
                                      `CMD_PROT_SETUP};
                        start_ff <= 1'b1;
                        state_ff <= S_W1;
                     end
                     default: state_ff <= S_IDLE;
                  endcase
               end
            end
            S_W1: begin
               if (cyc_done && prog_op) begin
                  // Second write: one 16-bit word, or the lock pattern.
                  if (op_ff == `OP_LOCK) begin
                     req_ff <= '{1'b1, `LOCK_WORD_ADDR,
                                 `LOCK_WORD_DATA};
                  end else begin
                     req_ff <= '{1'b1, addr_ff, wdata_ff};
                  end
                  start_ff <= 1'b1;
                  state_ff <= S_W2;
               end else if (cyc_done) begin
                  state_ff <= S_IDLE;
               end
            end
            S_W2: begin
               if (cyc_done) begin
                  req_ff   <= '{1'b0, addr_ff, 16'h0000};
                  start_ff <= 1'b1;
                  state_ff <= S_POLL;
               end
            end
            S_POLL: begin
               // Status reads repeat until the ready bit is seen.
               if (cyc_done && cyc_rdata[`SR_READY]) begin
                  sr_ff    <= cyc_rdata[7:0];
                  state_ff <= S_IDLE;
               end else if (cyc_done) begin
                  start_ff <= 1'b1;
               end
            end
            S_RD: begin
               if (cyc_done) begin
                  rdata_ff <= cyc_rdata;
                  state_ff <= S_IDLE;
               end
            end
            default: state_ff <= S_IDLE;
         endcase
      end
   end

   // ======================================================================
   // Checks.
   // The write strobe is seen low two and three edges after the start.
   chk_config_code: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      ctrl_wr && reg_wdata_in[2:0] == `OP_CONFIG |-> ##1 start_ff
      ##[2:3] (!fl_we_n_out && fl_dq_oe_out && fl_dq_out == 16'h0090))
      else $error("Config entry did not write 90h.");

   chk_array_code: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      ctrl_wr && reg_wdata_in[2:0] == `OP_ARRAY |-> ##[3:8]
      (!fl_we_n_out && fl_dq_out == 16'h00ff))
      else $error("Array return did not write FFh.");

   chk_setup_pair: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      cyc_done && state_ff == S_W1 && prog_op |=> start_ff && req_ff.wr
      && $past(fl_dq_out) == 16'h00c0)
      else $error("Setup C0h not followed by data write.");

   chk_word_once: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      state_ff == S_POLL |-> !(start_ff && req_ff.wr))
      else $error("Extra write while polling status.");

   chk_lock_word: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      state_ff == S_W2 && op_ff == `OP_LOCK && !fl_we_n_out |->
      fl_dq_out == 16'hfffd && fl_addr_out == `LOCK_WORD_ADDR)
      else $error("Lock write has wrong address or data.");

   chk_poll_ready: assert property (
      @(posedge mclk_in) disable iff (sys_rst_in)
      $past(state_ff) == S_POLL && state_ff == S_IDLE |-> sr_ff[7]
      && int_stat_ff[`INT_DONE])
      else $error("Program finished without ready status.");

endmodule
`default_nettype wire

// *** verification/flash_prot_model.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "flash_prot_map.svh"

module flash_prot_model #(
   parameter int          BUSY_READS  = 2,
   parameter logic [63:0] FACTORY_NUM = 64'h0123_4567_89ab_cdef // Arbitrary.
) (
   input  wire logic        rst_n_in,   // Flash reset, low active.
   input  wire logic        ce_n_in,    // Chip enable, low active.
   input  wire logic        oe_n_in,    // Output enable, low active.
   input  wire logic        we_n_in,    // Write enable, low active.
   input  wire logic [19:0] addr_in,    // Address from the host.
   input  wire logic [15:0] dq_in,      // Data written by the host.
   input  wire logic        vpp_low_in, // Supply below the lockout level.
   output logic [15:0]      dq_out      // Data driven back to the host.
);
   // ======================================================================
   // Storage: word 0 is the lock word, words 1 to 8 the register.
   logic [15:0] prot_mem [0:8];
   logic [1:0]  mode;
   logic        pend;
   logic [7:0]  sr;
   int          reads      = 0;
   int          prog_reads = 0;
   logic [15:0] rd_val;
   logic [15:0] last_val   = 16'h0000;
   logic [3:0]  idx;
   logic        in_range;

   // The window base sits on a 16-word boundary, so low bits index it.
   assign idx      = addr_in[3:0];
   assign in_range = (addr_in >= `LOCK_WORD_ADDR) &&
                     (addr_in <= `LOCK_WORD_ADDR + 20'h8);

   // Nonvolatile contents: factory half filled, user half blank.
   initial begin
      prot_mem[0] = 16'hfffe;
      for (int i = 0; i < 8; i++) begin
         prot_mem[i+1] = (i < 4) ? FACTORY_NUM[16*i +: 16]
                                 : 16'hffff;
      end
   end

   // Lock word bit 1 guards the user half, bit 0 the factory half.
   function automatic logic is_locked(input logic [3:0] w);
      if (w == 4'h0 || w > 4'h4) begin
         return !prot_mem[0][1];
      end
      return !prot_mem[0][0];
   endfunction

   // Command decode on the write strobe's rising edge; reset keeps contents.
   always @(negedge rst_n_in or posedge we_n_in) begin
      if (!rst_n_in) begin
         mode = 2'd0;
         pend = 1'b0;
         sr   = 8'h00;
      end else if (ce_n_in === 1'b0) begin
         if (pend) begin
            pend       = 1'b0;
            mode       = 2'd2;
            prog_reads = reads;
            if (vpp_low_in) sr = sr | 8'h08;
            else if (!in_range) sr = sr | 8'h10;
            else if (is_locked(idx)) sr = sr | 8'h12;
            else prot_mem[idx] = prot_mem[idx] & dq_in;
         end else if (dq_in[7:0] == 8'hff) mode = 2'd0;
         else if (dq_in[7:0] == 8'h90) mode = 2'd1;
         else if (dq_in[7:0] == 8'hc0) pend = 1'b1;
      end
   end

   // Each finished read counts toward the end of a program.
   always @(posedge oe_n_in) begin
      if (ce_n_in === 1'b0) begin
         last_val <= rd_val;
         reads    <= reads + 1;
      end
   end

   // Read data by mode; a released bus shows the inverse of the last word.
   always @* begin
      case (mode)
         2'd1: rd_val = in_range ? prot_mem[idx] : 16'h0000;
         2'd2: rd_val = {8'h00, sr | ((reads - prog_reads >= BUSY_READS) ?
                                      8'h80 : 8'h00)};
         default: rd_val = addr_in[15:0] ^ 16'h5a5a;
      endcase
   end
   assign dq_out = (ce_n_in == 1'b0 && oe_n_in == 1'b0) ? rd_val : ~last_val;
endmodule

`default_nettype wire

// *** verification/protection_register_access_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "flash_prot_map.svh"

module protection_register_access_tb_top;
   localparam logic [63:0] FACT = 64'h0123_4567_89ab_cdef; // Arbitrary.
   logic        mclk;
   logic        sys_rst;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        irq;
   logic        fl_rst_n;
   logic        fl_ce_n;
   logic        fl_oe_n;
   logic        fl_we_n;
   logic        fl_dq_oe;
   logic        vpp_low;
   logic [19:0] fl_addr;
   logic [15:0] fl_dq_out;
   logic [15:0] model_dq;
   logic [15:0] fl_dq_in;
   logic [31:0] rd_val;
   int          failures;
   int          checks;
   int          cycles;

   // Data wire level: host drives while its enable is high.
   assign fl_dq_in = fl_dq_oe ? fl_dq_out : model_dq;

   flash_prot_host DUT (.mclk_in(mclk), .sys_rst_in(sys_rst),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .irq_out(irq),
      .fl_rst_n_out(fl_rst_n), .fl_ce_n_out(fl_ce_n), .fl_oe_n_out(fl_oe_n),
      .fl_we_n_out(fl_we_n), .fl_addr_out(fl_addr), .fl_dq_out(fl_dq_out),
      .fl_dq_oe_out(fl_dq_oe), .fl_dq_in(fl_dq_in));

   flash_prot_model #(.BUSY_READS(2), .FACTORY_NUM(FACT)) flash (
      .rst_n_in(fl_rst_n), .ce_n_in(fl_ce_n), .oe_n_in(fl_oe_n),
      .we_n_in(fl_we_n), .addr_in(fl_addr), .dq_in(fl_dq_out),
      .vpp_low_in(vpp_low), .dq_out(model_dq));

   // ======================================================================
   // Clock and hang guard.
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         stop_test();
      end
   end

   // ======================================================================
   // Shared tasks for comparisons and register bus cycles.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask

   // Start an operation and poll busy under a bounded count.
   task automatic run(input logic [2:0] op);
      int n = 0;
      wr(`REG_CTRL, {29'h0, op});
      rd(`REG_STAT);
      while (rd_val[0] !== 1'b0 && n < 500) begin
         rd(`REG_STAT);
         n++;
      end
      chk({31'h0, rd_val[0]}, 32'h0);
   endtask

   task automatic prog(input logic [19:0] a, input logic [15:0] d);
      wr(`REG_ADDR, {12'h0, a});
      wr(`REG_WDATA, {16'h0, d});
      run(`OP_PROG);
   endtask

   task automatic rword(input logic [19:0] a, input logic [15:0] exp);
      wr(`REG_ADDR, {12'h0, a});
      run(`OP_READ);
      rd(`REG_RDATA);
      chk(rd_val, {16'h0, exp});
   endtask

   task automatic ist(input logic [31:0] exp);
      rd(`REG_INT_STATUS);
      chk(rd_val, exp);
   endtask

   task automatic do_reset();
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ======================================================================
   // Scenarios.
   task automatic t_idle();
      rd(`REG_STAT);
      chk(rd_val, 32'h0);
      ist(32'h0);
      wr(8'h40, 32'hffff_ffff);
      rd(8'h40);
      chk(rd_val, 32'h0);
      chk({26'h0, irq, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe, fl_rst_n},
          32'h1d);
      // An undefined op code starts nothing.
      wr(`REG_CTRL, 32'h7);
      rd(`REG_STAT);
      chk(rd_val, 32'h0);
      // A control write while busy is ignored.
      wr(`REG_CTRL, {29'h0, `OP_CONFIG});
      wr(`REG_CTRL, {29'h0, `OP_READ});
      repeat (20) @(posedge mclk);
      rd(`REG_CTRL);
      chk(rd_val, {29'h0, `OP_CONFIG});
      $display("test idle done");
   endtask

   task automatic t_modes();
      run(`OP_CONFIG);
      rword(20'h00081, FACT[15:0]);
      rword(20'h00084, FACT[63:48]);
      rword(`LOCK_WORD_ADDR, 16'hfffe);
      run(`OP_ARRAY);
      rword(20'h12345, 16'h2345 ^ 16'h5a5a);
      $display("test modes done");
   endtask

   task automatic t_program();
      wr(`REG_INT_ENABLE, 32'h2);
      rd(`REG_INT_ENABLE);
      chk(rd_val, 32'h2);
      for (int i = 0; i < 4; i++) begin
         prog(20'h00085 + 20'(i), 16'h1000 + 16'(i));
      end
      rd(`REG_WDATA);
      chk(rd_val, 32'h1003);
      rd(`REG_ADDR);
      chk(rd_val, 32'h88);
      ist(32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(`REG_INT_ENABLE, 32'h1);
      repeat (2) @(posedge mclk);
      #1 chk({31'h0, irq}, 32'h1);
      wr(`REG_INT_CLEAR, 32'hf);
      ist(32'h0);
      chk({31'h0, irq}, 32'h0);
      run(`OP_CONFIG);
      for (int i = 0; i < 4; i++) begin
         rword(20'h00085 + 20'(i), 16'h1000 + 16'(i));
      end
      $display("test program done");
   endtask

   task automatic t_errors();
      do_reset();
      prog(20'h00200, 16'h0000);
      ist(32'h3);
      do_reset();
      vpp_low <= 1'b1;
      prog(20'h00085, 16'h0000);
      ist(32'h9);
      vpp_low <= 1'b0;
      run(`OP_CONFIG);
      rword(20'h00085, 16'h1000);
      $display("test errors done");
   endtask

   task automatic t_lock();
      do_reset();
      run(`OP_LOCK);
      ist(32'h1);
      run(`OP_CONFIG);
      rword(`LOCK_WORD_ADDR, 16'hfffc);
      wr(`REG_INT_CLEAR, 32'hf);
      prog(20'h00086, 16'h0000);
      ist(32'h7);
      rd(`REG_STAT);
      chk(rd_val, 32'h0000_9200);
      do_reset();
      prog(20'h00086, 16'h0000);
      ist(32'h7);
      prog(20'h00081, 16'h0000);
      run(`OP_CONFIG);
      rword(20'h00086, 16'h1001);
      rword(20'h00081, FACT[15:0]);
      $display("test lock done");
   endtask

   // Main sequence.
   initial begin
      sys_rst   = 1'b1;
      reg_addr  = 8'h00;
      reg_wdata = 32'h0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      vpp_low   = 1'b0;
      failures  = 0;
      checks    = 0;
      cycles    = 0;
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      t_idle();
      t_modes();
      t_program();
      t_errors();
      t_lock();
      stop_test();
   end
endmodule

`default_nettype wire
